// ### design/rst_sup_pkg.sv
// Purpose: constants and types for the reset source supervisor
// Assumes: 200 MHz pclk, APB register access with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package rst_sup_pkg;
    // clock and timing
    localparam int CLK_MHZ            = 200;
    localparam int POR_MIN_NS         = 150;
    localparam int POR_MIN_CYC        = (POR_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STRETCH_W          = 8;
    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LVCFG  = 8'h08;
    localparam logic [7:0] OFS_WDT    = 8'h0C;
    localparam logic [7:0] OFS_BUZZ   = 8'h10;
    localparam logic [7:0] OFS_WDKICK = 8'h14;
    // control register bits
    localparam int CTRL_SWRST         = 0;
    localparam int CTRL_SWRST_DIS     = 1;
    localparam int CTRL_WDT_EN        = 2;
    localparam int CTRL_AREG_EN       = 3;
    // status register bits
    localparam int ST_POR             = 0;
    localparam int ST_PLV             = 1;
    localparam int ST_EXT             = 2;
    localparam int ST_SW              = 3;
    localparam int ST_WDT             = 4;
    localparam int ST_ALV             = 5;
    localparam int ST_DLV             = 6;
    localparam int ST_AHV             = 7;
    localparam int ST_LVRST           = 8;
    // lvcfg fields
    localparam int LV_ATRIP_LSB       = 0;
    localparam int LV_DTRIP_LSB       = 4;
    localparam int LV_AEN             = 8;
    localparam int LV_DEN             = 9;
    localparam int LV_HEN             = 10;
    localparam int LV_ARST            = 11;
    localparam int LV_DRST            = 12;
    // reset values and watchdog kick key
    localparam logic [15:0] WDT_RST   = 16'hFFFF;
    localparam logic [15:0] BUZZ_RST  = 16'h03FF;
    localparam logic [12:0] LV_RST    = 13'h0000;
    localparam logic [31:0] KICK_KEY  = 32'h0000_005A;
    localparam logic [3:0]  CTRL_RST  = 4'h8;
    localparam logic [8:0]  STATUS_RST = 9'h001;

    // supply comparator results, high when out of range
    typedef struct packed {
        logic plv_dig;
        logic plv_ana;
        logic alv;
        logic dlv;
        logic ahv;
    } mon_trip_t;

    // power mode
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'b001,
        PM_SLEEP  = 3'b010,
        PM_HIB    = 3'b100
    } pmode_t;

    // buzz sequencer states
    typedef enum logic [2:0] {
        BZ_IDLE  = 3'b001,
        BZ_ON    = 3'b010,
        BZ_WAKE  = 3'b100
    } buzz_st_t;
endpackage

// ### design/reset_source_supervisor.sv
// Purpose: merge supply, pin, software and watchdog resets into one reset
// Assumes: analog trip comparators and power mode come from outside
// Notes:   status survives every reset except power-on
`timescale 1ns/10ps
module reset_source_supervisor
    import rst_sup_pkg::*;
(
    // clock and power-on reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // supply monitors and power state
    input  wire mon_trip_t   mon_trip,
    input  wire pmode_t      pmode,
    input  wire logic        supply_ramping,
    input  wire logic        boot_done,
    output logic      [3:0]  alv_trip_level,
    output logic      [3:0]  dlv_trip_level,
    output logic             mon_enable,
    output logic             plv_enable,
    output logic             plv_ana_enable,
    output logic             wake_request,
    output logic             supply_irq,
    // external reset pins
    input  wire logic        external_reset_pin_n,
    input  wire logic        gpio_reset_n,
    input  wire logic        gpio_reset_sel,
    output logic             pullup_enable,
    // merged reset
    output logic             device_reset_n
);
    logic [1:0]   ext_sync;
    logic [1:0]   gpio_sync;
    logic [1:0]   ramp_sync;
    logic         ramping;
    logic         ext_low;
    logic [STRETCH_W-1:0] por_cnt;
    logic         por_active;
    logic         boot_seen;
    logic [3:0]   ctrl;
    logic [12:0]  lvcfg;
    logic [15:0]  wdt_limit;
    logic [15:0]  wdt_cnt;
    logic [15:0]  buzz_period;
    logic [15:0]  buzz_cnt;
    logic [8:0]   status;
    logic         sw_req;
    logic         wdt_fire;
    logic         plv_fire;
    logic         lv_rst_fire;
    logic         any_rst;
    logic [1:0]   rel_sync;
    logic         wr_en;
    logic         kick;
    logic         lv_irq_raw;
    logic         irq_pend;
    buzz_st_t     buzz_st;
    buzz_st_t     next_buzz_st;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // monitors may look at the supplies: awake, or a buzz while asleep
    function automatic logic mon_window(input pmode_t m, input buzz_st_t b);
        return m == PM_ACTIVE || (m == PM_SLEEP && b == BZ_ON);
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;                       // zero wait states
    assign pslverr = 1'b0;
    assign kick    = wr_en && hit(paddr, OFS_WDKICK) && pwdata == KICK_KEY;

    // pin synchronisers; pin held low keeps reset asserted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync  <= 2'b11;
            gpio_sync <= 2'b11;
            ramp_sync <= 2'b11;          // assume ramping until seen settled
        end else begin
            ext_sync  <= {ext_sync[0], external_reset_pin_n};
            gpio_sync <= {gpio_sync[0], gpio_reset_n};
            ramp_sync <= {ramp_sync[0], supply_ramping};
        end
    end
    // ramp flag comes from the analog side, so it is synchronised too
    assign ramping = ramp_sync[1];
    // either source behaves the same once selected
    assign ext_low = !ext_sync[1] || (gpio_reset_sel && !gpio_sync[1]);
    assign pullup_enable = 1'b1;          // pull-up held in all modes

    // power-on pulse stretched past the minimum while supplies ramp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt <= '0;
        end else if (ramping) begin
            por_cnt <= '0;
        end else if (por_cnt < STRETCH_W'(POR_MIN_CYC)) begin
            por_cnt <= por_cnt + 1'b1;
        end
    end
    assign por_active = por_cnt < STRETCH_W'(POR_MIN_CYC);

    // hand-over from the coarse monitor to the precise one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_seen <= 1'b0;
        end else if (boot_done && !por_active) begin
            boot_seen <= 1'b1;
        end
    end

    // precise monitor gating; digital half only follows power mode
    assign plv_enable = boot_seen && mon_window(pmode, buzz_st);
    assign plv_ana_enable = plv_enable && ctrl[CTRL_AREG_EN];
    assign plv_fire = plv_enable &&
        (mon_trip.plv_dig || (ctrl[CTRL_AREG_EN] && mon_trip.plv_ana));

    // level monitors run after power-on, only on buzz in sleep
    assign mon_enable = boot_seen && mon_window(pmode, buzz_st);
    assign alv_trip_level = lvcfg[LV_ATRIP_LSB +: 4];   // 250 mV steps
    assign dlv_trip_level = lvcfg[LV_DTRIP_LSB +: 4];
    assign lv_rst_fire = mon_enable &&
        ((lvcfg[LV_AEN] && lvcfg[LV_ARST] && mon_trip.alv) ||
         (lvcfg[LV_DEN] && lvcfg[LV_DRST] && mon_trip.dlv));
    assign lv_irq_raw = mon_enable &&
        ((lvcfg[LV_AEN] && !lvcfg[LV_ARST] && mon_trip.alv) ||
         (lvcfg[LV_DEN] && !lvcfg[LV_DRST] && mon_trip.dlv) ||
         (lvcfg[LV_HEN] && mon_trip.ahv));

    // buzz sequencer: periodic wake of monitors while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzz_cnt <= '0;
        end else if (pmode != PM_SLEEP || buzz_st != BZ_IDLE) begin
            buzz_cnt <= '0;
        end else begin
            buzz_cnt <= buzz_cnt + 1'b1;
        end
    end
    always_comb begin
        next_buzz_st = buzz_st;
        case (buzz_st)
            BZ_IDLE: begin
                if (pmode == PM_SLEEP && boot_seen &&
                    buzz_cnt >= buzz_period) begin
                    next_buzz_st = BZ_ON;
                end
            end
            BZ_ON: begin
                if (lv_irq_raw) begin
                    next_buzz_st = BZ_WAKE;
                end else begin
                    next_buzz_st = BZ_IDLE;
                end
            end
            BZ_WAKE: begin
                if (pmode == PM_ACTIVE) begin
                    next_buzz_st = BZ_IDLE;
                end
            end
            default: next_buzz_st = BZ_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzz_st <= BZ_IDLE;
        end else begin
            buzz_st <= next_buzz_st;
        end
    end
    assign wake_request = buzz_st == BZ_WAKE;

    // interrupt pends until active; shown only after wake-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pend <= 1'b0;
        end else if (lv_irq_raw) begin
            irq_pend <= 1'b1;
        end else if (pmode == PM_ACTIVE && !wake_request) begin
            irq_pend <= 1'b0;
        end
    end
    assign supply_irq = irq_pend && pmode == PM_ACTIVE && !wake_request;

    // software reset requested by cpu or dma write, unless disabled
    assign sw_req = wr_en && hit(paddr, OFS_CTRL) && pwdata[CTRL_SWRST] &&
        !ctrl[CTRL_SWRST_DIS];

    // writable control; watchdog enable sticky until power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= CTRL_RST;
            lvcfg       <= LV_RST;
            wdt_limit   <= WDT_RST;
            buzz_period <= BUZZ_RST;
        end else if (!device_reset_n) begin
            ctrl        <= {1'b1, ctrl[CTRL_WDT_EN], 2'b00};
            lvcfg       <= LV_RST;
            buzz_period <= BUZZ_RST;
        end else if (wr_en) begin
            if (hit(paddr, OFS_CTRL)) begin
                ctrl[CTRL_SWRST_DIS] <= pwdata[CTRL_SWRST_DIS];
                ctrl[CTRL_AREG_EN]   <= pwdata[CTRL_AREG_EN];
                ctrl[CTRL_WDT_EN] <= ctrl[CTRL_WDT_EN] |
                    pwdata[CTRL_WDT_EN];
            end
            if (hit(paddr, OFS_LVCFG)) begin
                lvcfg <= pwdata[12:0];
            end
            if (hit(paddr, OFS_WDT)) begin
                wdt_limit <= pwdata[15:0];
            end
            if (hit(paddr, OFS_BUZZ)) begin
                buzz_period <= pwdata[15:0];
            end
        end
    end

    // watchdog counts while enabled; restart by key write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt <= '0;
        end else if (!ctrl[CTRL_WDT_EN] || kick || !device_reset_n) begin
            wdt_cnt <= '0;
        end else if (wdt_cnt != wdt_limit) begin
            wdt_cnt <= wdt_cnt + 1'b1;
        end
    end
    // gated by the release flop, not the merged reset, to avoid a loop
    assign wdt_fire = ctrl[CTRL_WDT_EN] && wdt_cnt == wdt_limit &&
        rel_sync[1];

    // merge: assert at once, release through two flops
    assign any_rst = por_active || plv_fire || lv_rst_fire || ext_low ||
        sw_req || wdt_fire;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_sync <= 2'b00;
        end else if (any_rst) begin
            rel_sync <= 2'b00;
        end else begin
            rel_sync <= {rel_sync[0], 1'b1};
        end
    end
    assign device_reset_n = rel_sync[1] && !any_rst;

    // sticky status, set beats clear; reset to the por bit by power-on, cleared by writing ones to its bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RST;
        end else begin
            if (wr_en && hit(paddr, OFS_STATUS)) begin
                status <= status & ~pwdata[8:0];
            end
            if (plv_fire)    status[ST_PLV]   <= 1'b1;
            if (ext_low)     status[ST_EXT]   <= 1'b1;
            if (sw_req)      status[ST_SW]    <= 1'b1;
            if (wdt_fire)    status[ST_WDT]   <= 1'b1;
            if (lv_irq_raw && mon_trip.alv) status[ST_ALV] <= 1'b1;
            if (lv_irq_raw && mon_trip.dlv) status[ST_DLV] <= 1'b1;
            if (lv_irq_raw && mon_trip.ahv) status[ST_AHV] <= 1'b1;
            if (lv_rst_fire) status[ST_LVRST] <= 1'b1;
        end
    end

    // read mux, unmapped reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL:   prdata <= {28'h0, ctrl & 4'hE};
                OFS_STATUS: prdata <= {23'h0, status};
                OFS_LVCFG:  prdata <= {19'h0, lvcfg};
                OFS_WDT:    prdata <= {16'h0, wdt_limit};
                OFS_BUZZ:   prdata <= {16'h0, buzz_period};
                default:    prdata <= '0;
            endcase
        end
    end
endmodule

// ### bench/ext_reset_source.sv
// Purpose: model of the outside party that pulls a reset pin low
// Assumes: pin has a pull-up, so a released pin reads high
// Notes:   refuses to press again before the re-arm gap has run out
`timescale 1ns/10ps
module ext_reset_source #(
    parameter int GAP_CYC = 2000
) (
    // clock and pin
    input  wire logic pclk,
    output logic      pin_n
);
    int idle = GAP_CYC; // cycles since the pin was last released

    // released pin floats up to the pull-up level
    initial pin_n = 1'b1;

    // count the quiet time seen since the last release
    always @(posedge pclk) begin
        idle <= pin_n ? idle + 1 : 0;
    end

    // hold off until 10 us of quiet have passed, then pull low
    task automatic press();
        while (idle < GAP_CYC) @(posedge pclk);
        @(posedge pclk);
        pin_n <= 1'b0;
    endtask

    task automatic let_go();
        @(posedge pclk);
        pin_n <= 1'b1;
    endtask
endmodule

// ### bench/reset_source_supervisor_sva.sv
// Purpose: port-level checks of the merged reset supervisor
// Assumes: single pclk domain, presetn async active low
// Notes:   bound to every instance of the supervisor
`timescale 1ns/10ps
module reset_source_supervisor_sva
    import rst_sup_pkg::*;
(
    // clock, reset and register bus
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    // monitors
    input wire mon_trip_t  mon_trip,
    input wire pmode_t     pmode,
    input wire logic       boot_done,
    input wire logic [3:0] alv_trip_level,
    input wire logic       mon_enable,
    input wire logic       plv_enable,
    input wire logic       supply_irq,
    // pins and merged reset
    input wire logic       external_reset_pin_n,
    input wire logic       gpio_reset_n,
    input wire logic       gpio_reset_sel,
    input wire logic       device_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] since_por;
    logic       lv_wr;

    assign lv_wr = psel && penable && pwrite && paddr == OFS_LVCFG;

    // saturates at 255 so the counter never wraps back into the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_por <= 8'h00;
        else if (since_por != 8'hFF) since_por <= since_por + 8'h01;
    end

    chk_por_width: assert property (int'(since_por) < POR_MIN_CYC
        |-> !device_reset_n) else $error("power-on pulse too short");
    chk_mon_idle: assert property (int'(since_por) < POR_MIN_CYC
        |-> !mon_enable) else $error("monitors on during power-on");
    chk_pin_hold: assert property (!external_reset_pin_n[*3]
        |-> !device_reset_n) else $error("pin low but not in reset");
    chk_gpio_hold: assert property (
        (gpio_reset_sel && !gpio_reset_n)[*3] |-> !device_reset_n)
        else $error("gpio reset not honoured");
    chk_plv_trip: assert property (mon_trip.plv_dig && plv_enable
        |-> ##[0:2] !device_reset_n) else $error("precise trip ignored");
    chk_plv_always: assert property (pmode == PM_ACTIVE
        && $past(boot_done) && $past(device_reset_n) |-> plv_enable)
        else $error("precise monitor off");
    chk_hib_plv: assert property (pmode == PM_HIB |-> !plv_enable)
        else $error("precise monitor on in hibernate");
    chk_irq_asleep: assert property (
        pmode != PM_ACTIVE |-> !supply_irq)
        else $error("supply irq shown before wake");
    chk_level_hold: assert property (!lv_wr && device_reset_n ##1
        device_reset_n |-> $stable(alv_trip_level))
        else $error("trip level moved without a write");

    cover property (supply_irq);
    cover property ($fell(device_reset_n) && pmode == PM_HIB);
    cover property (mon_trip.plv_dig && plv_enable);
endmodule

bind reset_source_supervisor reset_source_supervisor_sva u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .mon_trip, .pmode,
    .boot_done, .alv_trip_level, .mon_enable, .plv_enable, .supply_irq,
    .external_reset_pin_n, .gpio_reset_n, .gpio_reset_sel, .device_reset_n
);

// ### bench/reset_source_supervisor_bench.sv
// Purpose: directed bench for the reset source supervisor
// Assumes: apb slave answers without wait states, pins pulled up
// Notes:   watchdog limit is shortened through its register
`timescale 1ns/10ps
module reset_source_supervisor_bench
    import rst_sup_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    mon_trip_t   mon_trip;
    pmode_t      pmode;
    logic        supply_ramping, boot_done, mon_enable, plv_enable;
    logic [3:0]  alv_trip_level, dlv_trip_level;
    logic        plv_ana_enable, wake_request, supply_irq, pullup_enable;
    logic        external_reset_pin_n, gpio_reset_n, gpio_reset_sel;
    logic        device_reset_n;
    int          n_fail, num_checks, cyc;
    logic [7:0]  ofs [5] = '{OFS_CTRL, OFS_LVCFG, OFS_WDT, OFS_BUZZ, 8'h18};
    logic [31:0] rv [5] = '{32'h8, 32'h0, 32'hFFFF, 32'h3FF, 32'h0};

    reset_source_supervisor u_reset_source_supervisor (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mon_trip, .pmode, .supply_ramping, .boot_done,
        .alv_trip_level, .dlv_trip_level, .mon_enable, .plv_enable,
        .plv_ana_enable, .wake_request, .supply_irq, .external_reset_pin_n,
        .gpio_reset_n, .gpio_reset_sel, .pullup_enable, .device_reset_n);
    ext_reset_source u_ext_pin (.pclk, .pin_n(external_reset_pin_n));
    ext_reset_source u_ext_gpio (.pclk, .pin_n(gpio_reset_n));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // outputs are looked at 1 ns after the edge, once they have settled
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    task automatic wait_dr(input logic v, input int lim);
        for (int i = 0; i < lim && device_reset_n !== v; i++) tick(1);
        chk({31'h0, device_reset_n}, {31'h0, v});
    endtask

    task automatic pin_cycle(input logic use_gpio);
        if (use_gpio) u_ext_gpio.press();
        else u_ext_pin.press();
        wait_dr(1'b0, 4);
        tick(20);
        chk({31'h0, device_reset_n}, 32'h0);
        if (use_gpio) u_ext_gpio.let_go();
        else u_ext_pin.let_go();
        wait_dr(1'b1, 40);
        rdchk(OFS_STATUS, 32'h1 << ST_EXT, 32'h1 << ST_EXT);
    endtask

    // directed sequence, watchdog last since it keeps firing
    initial begin
        {presetn, psel, penable, pwrite, boot_done, gpio_reset_sel} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mon_trip = '0;
        pmode = PM_ACTIVE;
        supply_ramping = 1'b1;
        {n_fail, num_checks, cyc} = '0;
        tick(8);
        presetn <= 1'b1;
        tick(50);
        chk({31'h0, device_reset_n}, 32'h0);
        supply_ramping <= 1'b0;
        wait_dr(1'b1, 40);
        boot_done <= 1'b1;
        foreach (ofs[i]) rdchk(ofs[i], 32'hFFFF_FFFF, rv[i]);
        chk({31'h0, pullup_enable}, 32'h1);
        chk({31'h0, pslverr}, 32'h0);
        xfer(1'b1, OFS_LVCFG, 32'h0000_0195);
        chk({dlv_trip_level, alv_trip_level}, 32'h95);
        mon_trip.alv <= 1'b1;
        tick(3);
        chk({31'h0, supply_irq}, 32'h1);
        rdchk(OFS_STATUS, 32'h1 << ST_ALV, 32'h1 << ST_ALV);
        mon_trip.alv <= 1'b0;
        xfer(1'b1, OFS_LVCFG, 32'h0000_0795);
        mon_trip <= '{dlv: 1'b1, ahv: 1'b1, default: 1'b0};
        tick(3);
        chk({31'h0, supply_irq}, 32'h1);
        rdchk(OFS_STATUS, 32'h0000_00C0, 32'h0000_00C0);
        mon_trip <= '0;
        xfer(1'b1, OFS_STATUS, 32'h0000_01FF);
        rdchk(OFS_STATUS, 32'h0000_01FF, 32'h0);
        xfer(1'b1, OFS_BUZZ, 32'h0000_0014);
        pmode <= PM_SLEEP;
        mon_trip.alv <= 1'b1;
        for (int i = 0; i < 80 && wake_request !== 1'b1; i++) tick(1);
        chk({wake_request, supply_irq}, 32'h2);
        pmode <= PM_ACTIVE;
        tick(3);
        chk({31'h0, supply_irq}, 32'h1);
        mon_trip.alv <= 1'b0;
        xfer(1'b1, OFS_LVCFG, 32'h0000_0995);
        mon_trip.alv <= 1'b1;
        wait_dr(1'b0, 5);
        mon_trip.alv <= 1'b0;
        wait_dr(1'b1, 40);
        rdchk(OFS_STATUS, 32'h1 << ST_LVRST, 32'h1 << ST_LVRST);
        xfer(1'b1, OFS_CTRL, 32'h0);
        chk({plv_enable, plv_ana_enable}, 32'h2);
        xfer(1'b1, OFS_CTRL, 32'h8);
        mon_trip.plv_dig <= 1'b1;
        wait_dr(1'b0, 4);
        mon_trip.plv_dig <= 1'b0;
        wait_dr(1'b1, 40);
        rdchk(OFS_STATUS, 32'h1 << ST_PLV, 32'h1 << ST_PLV);
        pmode <= PM_HIB;
        tick(2);
        chk({31'h0, plv_enable}, 32'h0);
        pmode <= PM_ACTIVE;
        xfer(1'b1, OFS_CTRL, 32'hA);
        xfer(1'b1, OFS_CTRL, 32'hB);
        tick(5);
        chk({31'h0, device_reset_n}, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h8);
        xfer(1'b1, OFS_CTRL, 32'h9);
        wait_dr(1'b0, 4);
        wait_dr(1'b1, 40);
        rdchk(OFS_STATUS, 32'h1 << ST_SW, 32'h1 << ST_SW);
        rdchk(OFS_CTRL, 32'hF, 32'h8);
        pin_cycle(1'b0);
        gpio_reset_sel <= 1'b1;
        pin_cycle(1'b1);
        pmode <= PM_HIB;
        pin_cycle(1'b0);
        pmode <= PM_ACTIVE;
        xfer(1'b1, OFS_WDT, 32'h0000_0028);
        xfer(1'b1, OFS_CTRL, 32'hC);
        repeat (6) begin
            xfer(1'b1, OFS_WDKICK, KICK_KEY);
            tick(10);
        end
        chk({31'h0, device_reset_n}, 32'h1);
        wait_dr(1'b0, 60);
        wait_dr(1'b1, 40);
        xfer(1'b1, OFS_CTRL, 32'h8);
        rdchk(OFS_CTRL, 32'h4, 32'h4);
        rdchk(OFS_STATUS, 32'h1 << ST_WDT, 32'h1 << ST_WDT);
        presetn <= 1'b0;
        tick(8);
        presetn <= 1'b1;
        wait_dr(1'b1, 60);
        rdchk(OFS_CTRL, 32'hF, 32'h8);
        rdchk(OFS_STATUS, 32'h1 << ST_WDT, 32'h0);
        give_verdict();
    end
endmodule
